// ---- rtl/synth_config_registers.sv ----
// Serial-loaded configuration register set of a fractional-N synthesizer
`timescale 1ns/10ps
// What this block does
// [R1] Shift 32-bit words MSB first on serial clock; latch on load strobe rise.
// [R2] Code 000 loads the divider register: integer, numerator, test output select.
// [R3] Twelve-bit integer field gives whole part of feedback division.
// [R4] Host keeps numerator below the modulus.
// [R5] Test output select comes from divider word bits 30 to 27.
// [R6] Code 001 loads the phase register.
// [R7] Phase word below modulus; output phase step is full turn over modulus.
// [R8] Host sets phase word to 1 when resync and spur tuning unused.
// [R9] Code 010 loads the modulus/reference register.
// [R10] Noise versus spur mode comes from modulus register bits 30 and 29.
// [R11] Lowest-spur mode enables dither; lowest-noise mode disables it.
// [R12] Slip reduction enabled while its enable bit is one.
// [R13] Host avoids slip reduction with negative sense; uses minimum pump current.
// [R14] Pump current selection comes from modulus register bits 27 to 24.
// [R15] Host picks 8/9 prescaler above 3 GHz.
// [R16] Host keeps integer at least 23 (4/5) or 75 (8/9).
// [R17] Halving bit inserts divide-by-two after the reference counter.
// [R18] Bit 20 doubles the reference ahead of the reference counter.
// [R19] Doubler off: falling edge active; doubler on: both edges active.
// [R20] Five-bit reference counter divides by 1 to 32.
// [R21] Twelve-bit modulus is the fractional denominator.
// [R22] Code 011 loads the function register bits.
// [R23] Buffered settings take effect only at next divider write.
// [R24] Counters held in reset while function bit 3 is one.
// [R25] Timer mode 00 off, 01 fast lock, 10 resync; 12-bit timeout.
// [R26] Codes 101 to 111 are ignored, registers unchanged.
// [R27] Reference count code zero means divide by 32.

module synth_config_registers (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic load_strobe,
  output logic [11:0] integer_value,
  output logic [11:0] divider_numerator,
  output logic [3:0] test_output_select,
  output logic [11:0] fraction_denominator,
  output logic [11:0] phase_word,
  output logic [5:0] ref_divide_ratio,
  output logic ref_doubler_on,
  output logic ref_both_edges_active,
  output logic reference_halving_enable,
  output logic [3:0] pump_current,
  output logic [1:0] noise_mode,
  output logic dither_enable,
  output logic slip_reduction_enable,
  output logic prescaler_high,
  output logic sd_restart_disable,
  output logic sd_restart_pulse,
  output logic lock_window_precision,
  output logic detector_sense,
  output logic power_down,
  output logic pump_float,
  output logic counters_held,
  output logic fast_lock_mode,
  output logic phase_resync_mode,
  output logic [11:0] timeout_count
);

  // Pin synchronisers: first stage feeds only the second
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic sclk_prev_q;
  logic strobe_prev_q;
  logic [31:0] shift_q;
  logic [31:0] divider_q;
  logic [31:0] phase_q;
  logic [31:0] modref_q;
  logic [31:0] function_q;
  logic [31:0] timer_q;
  synth_cfg_pkg::buffered_t active_q;
  logic restart_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {load_strobe, serial_data, serial_clock};
      sync2_q <= sync1_q;
    end
  end

  // Edge detection on the synchronised pins; 20 MHz limits serial rate to a few MHz
  wire sclk_rise = sync2_q[0] && !sclk_prev_q; // [R1]
  wire strobe_rise = sync2_q[2] && !strobe_prev_q; // [R1]
  wire [2:0] target = shift_q[2:0];
  wire wr_divider = strobe_rise && (target == synth_cfg_pkg::SEL_DIVIDER); // [R2]
  wire wr_phase = strobe_rise && (target == synth_cfg_pkg::SEL_PHASE); // [R6]
  wire wr_modref = strobe_rise && (target == synth_cfg_pkg::SEL_MODREF); // [R9]
  wire wr_function = strobe_rise && (target == synth_cfg_pkg::SEL_FUNCTION); // [R22]
  wire wr_timer = strobe_rise && (target == synth_cfg_pkg::SEL_TIMER);
  // Codes 101..111 match no decode above and so write nothing [R26]

  // Shift register, MSB first
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b0;
      strobe_prev_q <= 1'b0;
      shift_q <= synth_cfg_pkg::RESET_WORD;
    end else begin
      sclk_prev_q <= sync2_q[0];
      strobe_prev_q <= sync2_q[2];
      if (sclk_rise) begin
        shift_q <= {shift_q[30:0], sync2_q[1]}; // [R1]
      end
    end
  end

  // Staging latches, one per target code
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      divider_q <= synth_cfg_pkg::RESET_WORD;
      phase_q <= synth_cfg_pkg::RESET_WORD;
      modref_q <= synth_cfg_pkg::RESET_WORD;
      function_q <= synth_cfg_pkg::RESET_WORD;
      timer_q <= synth_cfg_pkg::RESET_WORD;
    end else begin
      if (wr_divider) divider_q <= shift_q; // [R2]
      if (wr_phase) phase_q <= shift_q; // [R6]
      if (wr_modref) modref_q <= shift_q; // [R9]
      if (wr_function) function_q <= shift_q; // [R22]
      if (wr_timer) timer_q <= shift_q; // [R25]
    end
  end

  // Buffered settings move to the active copy only on a divider write
  synth_cfg_pkg::buffered_t staged;
  assign staged.modulus = modref_q[synth_cfg_pkg::MOD_LSB +: 12];
  assign staged.phase = phase_q[synth_cfg_pkg::PHASE_LSB +: 12];
  assign staged.ref_count = modref_q[synth_cfg_pkg::RCNT_LSB +: 5];
  assign staged.doubler = modref_q[synth_cfg_pkg::DOUBLE_BIT];
  assign staged.halving = modref_q[synth_cfg_pkg::HALVE_BIT];
  assign staged.pump_current = modref_q[synth_cfg_pkg::PUMP_LSB +: 4];

  // Modulator restarts on each divider write unless function bit 14 disables it
  wire restart_d = wr_divider && !function_q[synth_cfg_pkg::SD_RESTART_BIT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= synth_cfg_pkg::BUF_RESET;
      restart_q <= 1'b0;
    end else begin
      if (wr_divider) active_q <= staged; // [R23]
      restart_q <= restart_d;
    end
  end

  // Field decode: ratio from active settings, noise and timer mode from staging latches
  wire [1:0] noise_d = modref_q[synth_cfg_pkg::NOISE_LSB +: 2]; // [R10]
  wire [5:0] ratio_d = (active_q.ref_count == 5'h00) ? 6'h20 : {1'b0, active_q.ref_count}; // [R20] [R27]
  wire [1:0] tmode_d = timer_q[synth_cfg_pkg::TMODE_LSB +: 2];

  // Output registers: every output comes from a flip-flop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      integer_value <= 12'h000;
      divider_numerator <= 12'h000;
      test_output_select <= 4'h0;
      fraction_denominator <= 12'h000;
      phase_word <= 12'h000;
      ref_divide_ratio <= 6'h20;
      ref_doubler_on <= 1'b0;
      ref_both_edges_active <= 1'b0;
      reference_halving_enable <= 1'b0;
      pump_current <= 4'h0;
      noise_mode <= 2'h0;
      dither_enable <= 1'b0;
      slip_reduction_enable <= 1'b0;
      prescaler_high <= 1'b0;
      sd_restart_disable <= 1'b0;
      sd_restart_pulse <= 1'b0;
      lock_window_precision <= 1'b0;
      detector_sense <= 1'b0;
      power_down <= 1'b0;
      pump_float <= 1'b0;
      counters_held <= 1'b0;
      fast_lock_mode <= 1'b0;
      phase_resync_mode <= 1'b0;
      timeout_count <= 12'h000;
    end else begin
      integer_value <= divider_q[synth_cfg_pkg::INT_LSB +: 12]; // [R3]
      divider_numerator <= divider_q[synth_cfg_pkg::NUM_LSB +: 12];
      test_output_select <= divider_q[synth_cfg_pkg::MUX_LSB +: 4]; // [R5]
      fraction_denominator <= active_q.modulus; // [R21]
      phase_word <= active_q.phase; // [R7]
      ref_divide_ratio <= ratio_d; // [R20]
      ref_doubler_on <= active_q.doubler; // [R18]
      ref_both_edges_active <= active_q.doubler; // [R19]
      reference_halving_enable <= active_q.halving; // [R17]
      pump_current <= active_q.pump_current; // [R14]
      noise_mode <= noise_d; // [R10]
      dither_enable <= (noise_d == synth_cfg_pkg::NOISE_LOWEST_SPUR); // [R11]
      slip_reduction_enable <= modref_q[synth_cfg_pkg::SLIP_BIT]; // [R12]
      prescaler_high <= modref_q[synth_cfg_pkg::PRESC_BIT];
      sd_restart_disable <= function_q[synth_cfg_pkg::SD_RESTART_BIT];
      sd_restart_pulse <= restart_q;
      lock_window_precision <= function_q[synth_cfg_pkg::LOCK_PREC_BIT];
      detector_sense <= function_q[synth_cfg_pkg::SENSE_BIT];
      power_down <= function_q[synth_cfg_pkg::PWRDN_BIT];
      // Power-down also floats the pump and holds the counters
      pump_float <= function_q[synth_cfg_pkg::FLOAT_BIT] || function_q[synth_cfg_pkg::PWRDN_BIT];
      counters_held <= function_q[synth_cfg_pkg::CNT_RESET_BIT] || function_q[synth_cfg_pkg::PWRDN_BIT]; // [R24]
      fast_lock_mode <= (tmode_d == synth_cfg_pkg::TMODE_FAST_LOCK); // [R25]
      phase_resync_mode <= (tmode_d == synth_cfg_pkg::TMODE_RESYNC); // [R25]
      timeout_count <= timer_q[synth_cfg_pkg::TDIV_LSB +: 12]; // [R25]
    end
  end

  // Checks
  property p_shift_msb_first;
    @(posedge clock) disable iff (!rst_n)
      sclk_rise |=> shift_q[0] == $past(sync2_q[1]) && shift_q[31:1] == $past(shift_q[30:0]);
  endproperty
  a_shift_msb_first: assert property (p_shift_msb_first) else $error("shift order wrong"); // [R1]

  property p_divider_int;
    @(posedge clock) disable iff (!rst_n)
      wr_divider |-> ##2 integer_value == $past(shift_q[26:15], 2);
  endproperty
  a_divider_int: assert property (p_divider_int) else $error("integer not loaded"); // [R3]

  property p_mux_sel;
    @(posedge clock) disable iff (!rst_n)
      wr_divider |-> ##2 test_output_select == $past(shift_q[30:27], 2);
  endproperty
  a_mux_sel: assert property (p_mux_sel) else $error("test select not loaded"); // [R5]

  property p_phase_buffered;
    @(posedge clock) disable iff (!rst_n)
      !wr_divider |=> active_q.phase == $past(active_q.phase);
  endproperty
  a_phase_buffered: assert property (p_phase_buffered) else $error("buffered value moved early"); // [R23]

  property p_modulus_applied;
    @(posedge clock) disable iff (!rst_n)
      wr_divider |-> ##2 fraction_denominator == $past(modref_q[14:3], 2);
  endproperty
  a_modulus_applied: assert property (p_modulus_applied) else $error("modulus not applied"); // [R21]

  property p_dither;
    @(posedge clock) disable iff (!rst_n)
      ##1 dither_enable == ($past(modref_q[30:29]) == 2'h3);
  endproperty
  a_dither: assert property (p_dither) else $error("dither mode wrong"); // [R11]

  property p_counter_hold;
    @(posedge clock) disable iff (!rst_n)
      function_q[3] |=> counters_held;
  endproperty
  a_counter_hold: assert property (p_counter_hold) else $error("counters not held"); // [R24]

  property p_ratio_32;
    @(posedge clock) disable iff (!rst_n)
      active_q.ref_count == 5'h00 |=> ref_divide_ratio == 6'h20;
  endproperty
  a_ratio_32: assert property (p_ratio_32) else $error("zero code not 32"); // [R27]

  property p_bad_code;
    @(posedge clock) disable iff (!rst_n)
      strobe_rise && target > 3'h4 |=> $stable(divider_q) && $stable(timer_q) && $stable(modref_q)
        && $stable(phase_q) && $stable(function_q);
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("reserved code wrote"); // [R26]

  // Routing checks compare each output with the latch it came from, except ref_both_edges_active, which is checked against its own expression
  property p_restart_pulse;
    @(posedge clock) disable iff (!rst_n)
      wr_divider |-> ##2 sd_restart_pulse == !$past(function_q[14], 2);
  endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("restart pulse wrong"); // [R22]

  property p_pulse_single;
    @(posedge clock) disable iff (!rst_n)
      sd_restart_pulse |=> !sd_restart_pulse;
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("restart pulse too long"); // [R22]

  property p_timer_mode;
    @(posedge clock) disable iff (!rst_n)
      ##1 ((fast_lock_mode == ($past(timer_q[20:19]) == 2'b01))
        && (phase_resync_mode == ($past(timer_q[20:19]) == 2'b10)));
  endproperty
  a_timer_mode: assert property (p_timer_mode) else $error("timer mode wrong"); // [R25]

  property p_timeout;
    @(posedge clock) disable iff (!rst_n)
      ##1 timeout_count == $past(timer_q[18:7]);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout count wrong"); // [R25]

  property p_slip_presc;
    @(posedge clock) disable iff (!rst_n)
      ##1 ((slip_reduction_enable == $past(modref_q[28])) && (prescaler_high == $past(modref_q[22])));
  endproperty
  a_slip_presc: assert property (p_slip_presc) else $error("slip or prescaler wrong"); // [R12]

  property p_pump_applied;
    @(posedge clock) disable iff (!rst_n)
      wr_divider |-> ##2 pump_current == $past(modref_q[27:24], 2);
  endproperty
  a_pump_applied: assert property (p_pump_applied) else $error("pump current not applied"); // [R14]

  property p_halving;
    @(posedge clock) disable iff (!rst_n)
      wr_divider |-> ##2 reference_halving_enable == $past(modref_q[21], 2);
  endproperty
  a_halving: assert property (p_halving) else $error("halving not applied"); // [R17]

  property p_doubler;
    @(posedge clock) disable iff (!rst_n)
      wr_divider |-> ##2 ref_doubler_on == $past(modref_q[20], 2);
  endproperty
  a_doubler: assert property (p_doubler) else $error("doubler not applied"); // [R18]

  property p_both_edges;
    @(posedge clock) disable iff (!rst_n)
      ##1 ref_both_edges_active == $past(active_q.doubler);
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("active edge choice wrong"); // [R19]

  property p_buffered_all;
    @(posedge clock) disable iff (!rst_n)
      !wr_divider |=> $stable(active_q);
  endproperty
  a_buffered_all: assert property (p_buffered_all) else $error("buffered set moved early"); // [R23]

  property p_ratio_range;
    @(posedge clock) disable iff (!rst_n)
      (ref_divide_ratio != 6'h00) && (ref_divide_ratio <= 6'h20);
  endproperty
  a_ratio_range: assert property (p_ratio_range) else $error("ratio out of range"); // [R20]

  // Power-down also holds the counters, so release is only checked with both bits clear
  property p_counter_release;
    @(posedge clock) disable iff (!rst_n)
      !function_q[3] && !function_q[5] |=> !counters_held;
  endproperty
  a_counter_release: assert property (p_counter_release) else $error("counters not released"); // [R24]

  c_divider_write: cover property (@(posedge clock) disable iff (!rst_n) wr_divider);
  c_modref_then_div: cover property (@(posedge clock) disable iff (!rst_n) wr_modref ##[1:200] wr_divider);
  c_fast_lock: cover property (@(posedge clock) disable iff (!rst_n) fast_lock_mode);
  c_reserved_code: cover property (@(posedge clock) disable iff (!rst_n) strobe_rise && target > 3'h4);
  c_restart_skipped: cover property (@(posedge clock) disable iff (!rst_n) wr_divider && function_q[14]);

endmodule // synth_config_registers

// ---- shared/synth_cfg_pkg.sv ----
// Package with field layout, codes and reset values of the synthesizer configuration registers
package synth_cfg_pkg;

  localparam int WORD_BITS = 32;

  // Target select codes in the low three bits
  localparam logic [2:0] SEL_DIVIDER = 3'h0;
  localparam logic [2:0] SEL_PHASE = 3'h1;
  localparam logic [2:0] SEL_MODREF = 3'h2;
  localparam logic [2:0] SEL_FUNCTION = 3'h3;
  localparam logic [2:0] SEL_TIMER = 3'h4;

  // Divider word fields
  localparam int MUX_LSB = 27;
  localparam int INT_LSB = 15;
  localparam int NUM_LSB = 3;
  // Phase word field
  localparam int PHASE_LSB = 3;
  // Modulus / reference word fields
  localparam int NOISE_LSB = 29;
  localparam int SLIP_BIT = 28;
  localparam int PUMP_LSB = 24;
  localparam int PRESC_BIT = 22;
  localparam int HALVE_BIT = 21;
  localparam int DOUBLE_BIT = 20;
  localparam int RCNT_LSB = 15;
  localparam int MOD_LSB = 3;
  // Function word bits
  localparam int SD_RESTART_BIT = 14;
  localparam int LOCK_PREC_BIT = 7;
  localparam int SENSE_BIT = 6;
  localparam int PWRDN_BIT = 5;
  localparam int FLOAT_BIT = 4;
  localparam int CNT_RESET_BIT = 3;
  // Timer word fields
  localparam int TMODE_LSB = 19;
  localparam int TDIV_LSB = 7;

  // Noise mode codes
  localparam logic [1:0] NOISE_LOWEST = 2'h0;
  localparam logic [1:0] NOISE_LOWEST_SPUR = 2'h3;

  // Clock divider modes
  typedef enum logic [1:0] {
    TMODE_OFF = 2'b00,
    TMODE_FAST_LOCK = 2'b01,
    TMODE_RESYNC = 2'b10,
    TMODE_RSVD = 2'b11
  } timer_mode_t;

  // Settings held behind the divider write
  typedef struct packed {
    logic [11:0] modulus;
    logic [11:0] phase;
    logic [4:0] ref_count;
    logic doubler;
    logic halving;
    logic [3:0] pump_current;
  } buffered_t;

  // Reset values: all-zero words, so counters are not held until a function write sets bit 3 or bit 5
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam buffered_t BUF_RESET = '0;

endpackage

// ---- testbench/serial_host.sv ----
// Host model that shifts configuration words into the three serial pins
`timescale 1ns/10ps
module serial_host (
  input wire logic clock,
  output logic serial_clock,
  output logic serial_data,
  output logic load_strobe
);
  // Pins start low; the serial clock stands still between frames
  initial begin
    serial_clock = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end

  // All pin changes happen on the falling system clock edge
  task automatic pause(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Each serial clock phase lasts four system clocks, above the two the synchroniser stages need
  task automatic send_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      serial_data = w[i];
      pause(4);
      serial_clock = 1'b1;
      pause(4);
      serial_clock = 1'b0;
    end
    pause(2);
    load_strobe = 1'b1;
    serial_data = ~w[0]; // Released data shows the inverse, so a stale bit cannot pass
    pause(4);
    load_strobe = 1'b0;
    pause(6);
  endtask
endmodule // serial_host

// ---- testbench/testbench.sv ----
// Self-checking bench for the serial configuration register set
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module testbench;
  logic clock;
  logic rst_n;
  logic serial_clock, serial_data, load_strobe;
  logic [11:0] integer_value, divider_numerator, fraction_denominator, phase_word, timeout_count;
  logic [3:0] test_output_select, pump_current;
  logic [5:0] ref_divide_ratio;
  logic [1:0] noise_mode;
  logic ref_doubler_on, ref_both_edges_active, reference_halving_enable, dither_enable;
  logic slip_reduction_enable, prescaler_high, sd_restart_disable, sd_restart_pulse;
  logic lock_window_precision, detector_sense, power_down, pump_float, counters_held;
  logic fast_lock_mode, phase_resync_mode;
  int mismatches = 0;
  int num_checks = 0;
  int pulses = 0;
  // Function bits 7..3 sent, and expected lock, sense, power, float, held
  logic [4:0] fin [3] = '{5'b11001, 5'b01100, 5'b01000};
  logic [4:0] fexp [3] = '{5'b11001, 5'b01111, 5'b01000};
  // Grouped views keep the compare lines short
  wire [4:0] mode_view = {noise_mode, dither_enable, slip_reduction_enable, prescaler_high};
  wire [4:0] func_view = {lock_window_precision, detector_sense, power_down, pump_float, counters_held};
  wire [27:0] div_view = {integer_value, divider_numerator, test_output_select};
  wire [36:0] buf_view = {fraction_denominator, phase_word, ref_divide_ratio, ref_doubler_on,
    ref_both_edges_active, reference_halving_enable, pump_current};

  synth_config_registers DUT (.clock(clock), .rst_n(rst_n), .serial_clock(serial_clock),
    .serial_data(serial_data), .load_strobe(load_strobe), .integer_value(integer_value),
    .divider_numerator(divider_numerator), .test_output_select(test_output_select),
    .fraction_denominator(fraction_denominator), .phase_word(phase_word),
    .ref_divide_ratio(ref_divide_ratio), .ref_doubler_on(ref_doubler_on),
    .ref_both_edges_active(ref_both_edges_active), .reference_halving_enable(reference_halving_enable),
    .pump_current(pump_current), .noise_mode(noise_mode), .dither_enable(dither_enable),
    .slip_reduction_enable(slip_reduction_enable), .prescaler_high(prescaler_high),
    .sd_restart_disable(sd_restart_disable), .sd_restart_pulse(sd_restart_pulse),
    .lock_window_precision(lock_window_precision), .detector_sense(detector_sense),
    .power_down(power_down), .pump_float(pump_float), .counters_held(counters_held),
    .fast_lock_mode(fast_lock_mode), .phase_resync_mode(phase_resync_mode),
    .timeout_count(timeout_count));

  serial_host host (.clock(clock), .serial_clock(serial_clock), .serial_data(serial_data),
    .load_strobe(load_strobe));

  // System clock, 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // The restart pulse lasts one cycle; count it at the falling edge, where it has settled
  always @(negedge clock) begin
    if (sd_restart_pulse === 1'b1) pulses++;
  end

  // Prints the counts and the verdict, then ends the run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence follows the usual power-up order: timer, function, modulus, phase, divider
  initial begin
    rst_n = 1'b0;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    `CHK("ratio_rst", 6'h20, ref_divide_ratio)
    `CHK("den_rst", 12'h000, fraction_denominator)
    for (int m = 0; m < 4; m++) begin
      host.send_word({11'h0, 2'(m), 12'h123 + 12'(m), 4'h0, synth_cfg_pkg::SEL_TIMER});
      `CHK("fast_lock", (m == 1), fast_lock_mode)
      `CHK("resync", (m == 2), phase_resync_mode)
      `CHK("timeout", 12'h123 + 12'(m), timeout_count)
    end
    for (int k = 0; k < 3; k++) begin
      host.send_word({17'h0, 1'b0, 6'h0, fin[k], synth_cfg_pkg::SEL_FUNCTION});
      `CHK("function", fexp[k], func_view)
    end
    `CHK("sd_disable", 1'b0, sd_restart_disable)
    // Slip reduction on with minimum pump current and positive sense
    host.send_word({1'b0, 2'b11, 1'b1, 4'h0, 1'b0, 3'b111, 5'h00, 12'd65, synth_cfg_pkg::SEL_MODREF});
    `CHK("mode_a", 5'b11111, mode_view)
    `CHK("buf_held", {12'h000, 12'h000, 6'h20, 3'b000, 4'h0}, buf_view)
    host.send_word({17'h0, 12'd1, synth_cfg_pkg::SEL_PHASE});
    `CHK("phase_held", 12'h000, phase_word)
    pulses = 0;
    host.send_word({1'b0, 4'ha, 12'd138, 12'd30, synth_cfg_pkg::SEL_DIVIDER});
    `CHK("divider", {12'd138, 12'd30, 4'ha}, div_view)
    `CHK("buf_a", {12'd65, 12'd1, 6'd32, 3'b111, 4'h0}, buf_view)
    `CHK("restart", 1'b1, (pulses == 1))
    // Lowest-noise mode, slower input on the 4/5 prescaler
    host.send_word({1'b0, 2'b00, 1'b0, 4'h9, 1'b0, 3'b000, 5'd5, 12'd100, synth_cfg_pkg::SEL_MODREF});
    `CHK("mode_b", 5'b00000, mode_view)
    `CHK("pump_held", 4'h0, pump_current)
    // Unassigned codes carry values that would show up anywhere they landed
    for (int c = 5; c < 8; c++) begin
      host.send_word({1'b0, 2'b11, 1'b1, 4'hf, 1'b0, 3'b111, 5'h1f, 12'hfff, 3'(c)});
    end
    `CHK("ignored", {5'b00000, 12'h126, 1'b0}, {mode_view, timeout_count, power_down})
    host.send_word({1'b0, 4'h3, 12'd200, 12'd99, synth_cfg_pkg::SEL_DIVIDER});
    `CHK("divider_b", {12'd200, 12'd99, 4'h3}, div_view)
    `CHK("buf_b", {12'd100, 12'd1, 6'd5, 3'b000, 4'h9}, buf_view)
    // Restart disabled: the next divider write must leave the modulator alone
    host.send_word({17'h0, 1'b1, 6'h0, 5'b01000, synth_cfg_pkg::SEL_FUNCTION});
    `CHK("sd_disable_on", 1'b1, sd_restart_disable)
    pulses = 0;
    host.send_word({1'b0, 4'h3, 12'd200, 12'd99, synth_cfg_pkg::SEL_DIVIDER});
    `CHK("restart_off", 1'b0, (pulses != 0))
    report_and_stop();
  end

  // About seventeen words of some 270 cycles each; the limit leaves ample margin
  initial begin
    repeat (12000) @(posedge clock);
    mismatches++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule // testbench
